// >>> verilog/mcd_consts.svh
// Register offsets, field positions, reset values and masks of the modem configuration slice
`ifndef MCD_CONSTS_SVH
`define MCD_CONSTS_SVH

`define MCD_ADDR_W            6
`define MCD_OFS_CODING_PRE    6'h13
`define MCD_OFS_SPACING_M     6'h14
`define MCD_OFS_DEVIATION     6'h15

`define MCD_RST_CODING_PRE    8'h22
`define MCD_RST_SPACING_M     8'hF8
`define MCD_RST_DEVIATION     8'h47

`define MCD_MASK_CODING_PRE   8'hF3
`define MCD_MASK_SPACING_M    8'hFF
`define MCD_MASK_DEVIATION    8'h77

`define MCD_BIT_FEC           7
`define MCD_POS_PRE           4
`define MCD_POS_SPC_E         0
`define MCD_POS_DEV_E         4
`define MCD_POS_DEV_M         0

`define MCD_SPC_OFFSET        13'h0100
`define MCD_DEV_OFFSET        4'h8

`endif

// >>> verilog/mcd_pkg.sv
// Types shared by the modem configuration slice
`default_nettype none
`include "mcd_consts.svh"
package mcd_pkg;

  typedef enum logic [2:0] {
    MCD_MOD_2FSK,
    MCD_MOD_GFSK,
    MCD_MOD_ASK_OOK,
    MCD_MOD_4FSK_RSVD,
    MCD_MOD_MSK
  } mcd_mod_e;

  typedef struct packed {
    logic       payload_error_correction_enable;
    logic [2:0] preamble_code;
    logic [1:0] spacing_exponent;
    logic [7:0] spacing_mantissa;
    logic [2:0] deviation_exponent;
    logic [2:0] deviation_mantissa;
  } mcd_cfg_s;

  typedef struct packed {
    logic [`MCD_ADDR_W-1:0] addr;
    logic                   wr;
    logic                   rd;
    logic [7:0]             wdata;
  } mcd_req_s;

endpackage

`default_nettype wire

// >>> verilog/mcd_modem_cfg.sv
// Modem coding, preamble, channel spacing and deviation configuration registers with derived settings
// Behaviour
// - With the error correction enable set the payload gets error correction and interleaving, otherwise none.
// - At least 2, 3, 4, 6, 8, 12, 16 or 24 preamble bytes are sent for codes 0 to 7, code 2 after reset.
// - Channel spacing is fxosc/2^18 times (256 + mantissa) times 2 to the spacing exponent.
// - The operating frequency is the base frequency plus channel spacing times the channel index.
// - For 2-FSK and GFSK transmit the deviation is fxosc/2^17 times (8 + mantissa) times 2 to the exponent.
// - In 2-FSK and GFSK transmit a zero symbol shifts by minus the deviation and a one by plus.
// - In MSK transmit the mantissa picks the 1/8 to 8/8 symbol fraction of a +90 (zero) or -90 (one) degree turn.
// - In 2-FSK or GFSK receive the deviation is the expected one; otherwise outside FSK and MSK transmit it has no effect.
`timescale 1ns/1ps
`default_nettype none
`include "mcd_consts.svh"

module mcd_modem_cfg
  import mcd_pkg::*;
#(
  parameter int FREQ_W = 24
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire mcd_req_s          req,
  output logic [7:0]             rdata,
  input  wire logic              tx_active,
  input  wire logic              rx_active,
  input  wire mcd_mod_e          mod_format,
  input  wire logic              tx_symbol,
  input  wire logic [7:0]        channel_index,
  input  wire logic [FREQ_W-1:0] base_freq,
  input  wire logic [1:0]        packet_length_select,
  output logic                   payload_error_correction_enable,
  output logic                   fec_fixed_length_ok,
  output logic [4:0]             preamble_bytes,
  output logic [11:0]            spacing_units,
  output logic [FREQ_W-1:0]      operating_freq,
  output logic [10:0]            deviation_units,
  output logic signed [11:0]     tx_freq_offset,
  output logic [3:0]             msk_phase_eighths,
  output logic                   msk_phase_negative,
  output logic [10:0]            rx_expected_deviation
);

  logic [7:0] coding_pre_reg;
  logic [7:0] spacing_m_reg;
  logic [7:0] deviation_reg;
  mcd_cfg_s   cfg;
  logic       fsk_like;

  function automatic logic [4:0] preamble_lut(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h02;
    unique case (code)
      3'h0: n = 5'h02;
      3'h1: n = 5'h03;
      3'h2: n = 5'h04;
      3'h3: n = 5'h06;
      3'h4: n = 5'h08;
      3'h5: n = 5'h0C;
      3'h6: n = 5'h10;
      3'h7: n = 5'h18;
    endcase
    return n;
  endfunction

  function automatic logic [11:0] spacing_calc(input logic [7:0] m, input logic [1:0] e);
    logic [12:0] base;
    base = `MCD_SPC_OFFSET + {5'h00, m};
    return 12'(base[8:0]) << e;
  endfunction

  function automatic logic [10:0] deviation_calc(input logic [2:0] m, input logic [2:0] e);
    logic [3:0] base;
    base = `MCD_DEV_OFFSET | {1'b0, m};
    return 11'({7'h00, base} << e);
  endfunction

  // One driver for the whole struct keeps the field split in a single place
  assign cfg = '{
    payload_error_correction_enable: coding_pre_reg[`MCD_BIT_FEC],
    preamble_code:                   coding_pre_reg[`MCD_POS_PRE +: 3],
    spacing_exponent:                coding_pre_reg[`MCD_POS_SPC_E +: 2],
    spacing_mantissa:                spacing_m_reg,
    deviation_exponent:              deviation_reg[`MCD_POS_DEV_E +: 3],
    deviation_mantissa:              deviation_reg[`MCD_POS_DEV_M +: 3]
  };
  assign fsk_like = (mod_format == MCD_MOD_2FSK) || (mod_format == MCD_MOD_GFSK);

  // Unused positions are masked on write so they can never hold a one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      coding_pre_reg <= `MCD_RST_CODING_PRE;
      spacing_m_reg  <= `MCD_RST_SPACING_M;
      deviation_reg  <= `MCD_RST_DEVIATION;
    end else if (req.wr) begin
      unique case (req.addr)
        `MCD_OFS_CODING_PRE: coding_pre_reg <= req.wdata & `MCD_MASK_CODING_PRE;
        `MCD_OFS_SPACING_M:  spacing_m_reg  <= req.wdata & `MCD_MASK_SPACING_M;
        `MCD_OFS_DEVIATION:  deviation_reg  <= req.wdata & `MCD_MASK_DEVIATION;
        default: ;
      endcase
    end
  end

  // Read data lands one cycle after the read strobe; unmapped addresses read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        `MCD_OFS_CODING_PRE: rdata <= coding_pre_reg;
        `MCD_OFS_SPACING_M:  rdata <= spacing_m_reg;
        `MCD_OFS_DEVIATION:  rdata <= deviation_reg;
        default:             rdata <= 8'h00;
      endcase
    end
  end

  // Coding and preamble controls for the packet engine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      payload_error_correction_enable <= 1'b0;
      fec_fixed_length_ok             <= 1'b1;
      preamble_bytes                  <= 5'h04;
    end else begin
      payload_error_correction_enable <= cfg.payload_error_correction_enable;
      // Coding relies on the host keeping fixed length; flag a misuse but do not override it
      fec_fixed_length_ok <= !cfg.payload_error_correction_enable || (packet_length_select == 2'h0);
      preamble_bytes      <= preamble_lut(cfg.preamble_code);
    end
  end

  // Spacing and frequency in two stages to keep the multiplier off the register path
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spacing_units  <= 12'h000;
      operating_freq <= '0;
    end else begin
      spacing_units  <= spacing_calc(cfg.spacing_mantissa, cfg.spacing_exponent);
      operating_freq <= base_freq + FREQ_W'(spacing_units * channel_index);
    end
  end

  // Deviation, symbol offset and MSK phase controls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      deviation_units       <= 11'h000;
      tx_freq_offset        <= 12'sh000;
      msk_phase_eighths     <= 4'h8;
      msk_phase_negative    <= 1'b0;
      rx_expected_deviation <= 11'h000;
    end else begin
      deviation_units <= deviation_calc(cfg.deviation_mantissa, cfg.deviation_exponent);
      if (tx_active && fsk_like) begin
        tx_freq_offset <= tx_symbol ? $signed({1'b0, deviation_units})
                                    : -$signed({1'b0, deviation_units});
      end else begin
        tx_freq_offset <= 12'sh000;
      end
      msk_phase_eighths  <= {1'b0, cfg.deviation_mantissa} + 4'h1;
      msk_phase_negative <= tx_active && (mod_format == MCD_MOD_MSK) && tx_symbol;
      rx_expected_deviation <= (rx_active && fsk_like) ? deviation_units : 11'h000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_spacing_write;
    req.wr && (req.addr == `MCD_OFS_SPACING_M);
  endsequence

  sequence s_spacing_settled;
    ##2 1'b1;
  endsequence

  property p_fec_follows;
    (cfg.payload_error_correction_enable ##1 cfg.payload_error_correction_enable)
      |-> payload_error_correction_enable;
  endproperty
  a_fec_follows: assert property (p_fec_follows) else $error("error correction enable not applied");

  property p_preamble_max;
    (cfg.preamble_code == 3'h7) |=> (preamble_bytes == 5'h18);
  endproperty
  a_preamble_max: assert property (p_preamble_max) else $error("preamble code 7 not 24 bytes");

  property p_preamble_min;
    (cfg.preamble_code == 3'h0) |=> (preamble_bytes == 5'h02);
  endproperty
  a_preamble_min: assert property (p_preamble_min) else $error("preamble code 0 not 2 bytes");

  property p_spacing;
    (s_spacing_write ##1 !req.wr [*2]) |->
      (spacing_units == 12'(({4'h0, 1'b1, $past(req.wdata, 2)}) << $past(cfg.spacing_exponent)));
  endproperty
  a_spacing: assert property (p_spacing) else $error("channel spacing mismatch");

  property p_freq;
    1'b1 |=> (operating_freq == $past(base_freq) + FREQ_W'($past(spacing_units) * $past(channel_index)));
  endproperty
  a_freq: assert property (p_freq) else $error("operating frequency mismatch");

  property p_dev_sign;
    (tx_active && fsk_like && !tx_symbol) |=> (tx_freq_offset == -$signed({1'b0, $past(deviation_units)}));
  endproperty
  a_dev_sign: assert property (p_dev_sign) else $error("zero symbol not negative deviation");

  property p_dev_value;
    (cfg.deviation_mantissa == 3'h7 && cfg.deviation_exponent == 3'h4) |=> (deviation_units == 11'h0F0);
  endproperty
  a_dev_value: assert property (p_dev_value) else $error("deviation value mismatch");

  property p_msk_fraction;
    (cfg.deviation_mantissa == 3'h0) |=> (msk_phase_eighths == 4'h1);
  endproperty
  a_msk_fraction: assert property (p_msk_fraction) else $error("MSK fraction mismatch");

  property p_no_effect;
    (!(tx_active && fsk_like)) |=> (tx_freq_offset == 12'sh000) &&
      ($past(rx_active && fsk_like) || rx_expected_deviation == 11'h000);
  endproperty
  a_no_effect: assert property (p_no_effect) else $error("deviation applied outside FSK");

  property p_unused_zero;
    (req.rd && req.addr == `MCD_OFS_DEVIATION) |=> (rdata[7] == 1'b0 && rdata[3] == 1'b0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused deviation bits not zero");

endmodule

`default_nettype wire

// >>> sim/mcd_host_model.sv
// Host model that drives the register strobe port
`timescale 1ns/1ps
`default_nettype none
`include "mcd_consts.svh"
module mcd_host_model
  import mcd_pkg::*;
(
  input  wire logic clock,
  output var mcd_req_s req
);
  initial req = '0;
  // Idle address and data show the inverse of the last value, never a stale copy
  task automatic access(input logic [5:0] a, input logic w, input logic [7:0] d);
    @(posedge clock);
    #1;
    req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clock);
    #1;
    req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the modem configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "mcd_consts.svh"
module tb_top;
  import mcd_pkg::*;
  logic               clock, rst, tx_active, rx_active, tx_symbol, fec, fec_ok, msk_neg, rd_q, fsk;
  mcd_req_s           req;
  mcd_mod_e           mod_format;
  logic [7:0]         rdata, ch;
  logic [23:0]        base, freq;
  logic [1:0]         pls;
  logic [4:0]         pre;
  logic [11:0]        spc, sp, eo;
  logic [10:0]        dev, rxdev, dv;
  logic signed [11:0] ofs;
  logic [3:0]         eighths;
  logic [31:0]        lfsr;
  logic [7:0]         expq[$];
  logic [4:0]         tbl[8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10, 5'h18};
  int                 mismatches = 0, samples_checked = 0, cycles = 0;

  mcd_host_model mcd_host_model_inst (.clock(clock), .req(req));
  mcd_modem_cfg mcd_modem_cfg_inst (.clock(clock), .rst(rst), .req(req), .rdata(rdata),
    .tx_active(tx_active), .rx_active(rx_active), .mod_format(mod_format), .tx_symbol(tx_symbol),
    .channel_index(ch), .base_freq(base), .packet_length_select(pls),
    .payload_error_correction_enable(fec), .fec_fixed_length_ok(fec_ok), .preamble_bytes(pre),
    .spacing_units(spc), .operating_freq(freq), .deviation_units(dev), .tx_freq_offset(ofs),
    .msk_phase_eighths(eighths), .msk_phase_negative(msk_neg), .rx_expected_deviation(rxdev));

  task automatic end_sim();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t read %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    mcd_host_model_inst.access(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    expq.push_back(e);
    mcd_host_model_inst.access(a, 1'b0, 8'h00);
  endtask
  // Derived outputs trail a write by up to two edges
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] v);
    for (int k = 0; k < 32; k++) begin
      v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    end
    return v;
  endfunction

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    rd_q <= req.rd;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  // Read data is looked at mid-cycle, after the answering edge has landed
  always @(negedge clock) begin
    if (rd_q === 1'b1) begin
      check_rd(rdata, expq.pop_front());
    end
  end

  initial begin
    rst = 1'b1;
    {tx_active, rx_active, tx_symbol, ch, base, pls} = 37'h00_0000_0000;
    mod_format = MCD_MOD_2FSK;
    lfsr = 32'h0000_033d;
    repeat (3) @(posedge clock);
    #1;
    rst = 1'b0;
    rd(`MCD_OFS_CODING_PRE, 8'h22);
    rd(`MCD_OFS_SPACING_M, 8'hF8);
    rd(`MCD_OFS_DEVIATION, 8'h47);
    wr(6'h16, 8'hFF);
    rd(6'h16, 8'h00);
    wr(`MCD_OFS_DEVIATION, 8'hFF);
    rd(`MCD_OFS_DEVIATION, 8'h77);
    // Odd codes also set error correction, sometimes outside fixed length on purpose
    for (int c = 0; c < 8; c++) begin
      pls = 2'(c % 3);
      wr(`MCD_OFS_CODING_PRE, {c[0], c[2:0], 4'hD});
      settle();
      check(24'(pre), 24'(tbl[c]));
      check(24'(fec), 24'(c[0]));
      check(24'(fec_ok), 24'(!(c[0] && pls != 2'h0)));
      rd(`MCD_OFS_CODING_PRE, {c[0], c[2:0], 4'h1});
    end
    for (int i = 0; i < 15; i++) begin
      lfsr = nxt(lfsr);
      {ch, base} = {lfsr[31:24], lfsr[23:0] ^ 24'h5A_5A5A};
      {tx_symbol, tx_active, rx_active} = {lfsr[8], lfsr[9], !lfsr[9]};
      mod_format = mcd_mod_e'(3'(i % 5));
      // Spacing goes last so the quiet cycles after it let the spacing assertion see its write
      wr(`MCD_OFS_CODING_PRE, {6'h00, lfsr[11:10]});
      wr(`MCD_OFS_DEVIATION, {1'b0, lfsr[14:12], 1'b0, lfsr[18:16]});
      wr(`MCD_OFS_SPACING_M, lfsr[7:0]);
      settle();
      sp = 12'((12'h100 + lfsr[7:0]) << lfsr[11:10]);
      dv = 11'((11'h008 + lfsr[18:16]) << lfsr[14:12]);
      fsk = mod_format == MCD_MOD_2FSK || mod_format == MCD_MOD_GFSK;
      eo = tx_symbol ? {1'b0, dv} : 12'h000 - {1'b0, dv};
      check(24'(spc), 24'(sp));
      check(freq, base + 24'(sp) * 24'(ch));
      check(24'(dev), 24'(dv));
      check({12'h000, ofs}, {12'h000, (tx_active && fsk) ? eo : 12'h000});
      check(24'(eighths), 24'({1'b0, lfsr[18:16]} + 4'h1));
      check(24'(msk_neg), 24'(tx_active && mod_format == MCD_MOD_MSK && tx_symbol));
      check(24'(rxdev), (rx_active && fsk) ? 24'(dv) : 24'h00_0000);
      rd(`MCD_OFS_SPACING_M, lfsr[7:0]);
    end
    settle();
    end_sim();
  end
endmodule
`default_nettype wire
